// *** hdl/sps_sequencer.sv ***
// Operation
// (R1) Shutdown keeps pulse outputs high impedance
// (R2) Leave shutdown when all supplies enabled
// (R3) Enable comparator 0.66V with 100mV hysteresis
// (R4) Second, third driver supplies per phase count
// (R5) Reference ramps linearly to programmed level
// (R6) Pulse outputs float until ramp reaches output
// (R7) 64-cycle delay, then 1280 cycles per volt
// (R8) 100mV sense offset decays over 640 cycles
// (R9) Feedback above ramp holds both gates off
// (R10) Precharged output enables drives at ramp end
// (R11) Open-drain power good, low in shutdown
// (R12) Power good low on faults or disable
// (R13) Power good returns when within limits
// (R14) Below 82% pulls power good low only
// (R15) Undervoltage clears above 85% reference
// (R16) Upper released at switch-node trip points
// (R17) Zero load: upper 35ns after lower low
// (R18) Blank lower-gate fall on switch node
// (R19) Lower released by upper or switch level
// (R20) Counters tick per switching cycle, clear shut
// (R21) Two select pins pick ramp target
`timescale 1ns/1ps

module sps_sequencer (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   // Supply and enable comparators
   input  wire sps_pkg::sps_supply_t supplyIn,
   input  wire logic [1:0]           phaseCount,
   input  wire logic                 ref_select_low,
   input  wire logic                 ref_select_high,
   // Switching clock
   input  wire logic                 switchClock,
   // Output-voltage comparators
   input  wire sps_pkg::sps_sense_t  senseIn,
   // Gate-drive comparators and modulator
   input  wire sps_pkg::sps_gate_t   gateIn,
   // Pulse outputs and gates
   output logic                      pwmOutEnable,
   output logic                      upper_gate_drive,
   output logic                      lower_gate_drive,
   // Reference and offset codes
   output logic [10:0]               refCode,
   output logic [10:0]               senseOffsetCode,
   // Power good, open drain
   output logic                      power_good_output,
   output logic                      powerGoodOe,
   // Status
   output logic                      softStartDone,
   output sps_pkg::sps_seq_t         seqState
);

   // ==========================================================
   // Input synchronisers
   localparam int unsigned SYNC_W = 6 + 2 + 2 + 1 + 5 + 6;

   logic [SYNC_W-1:0] asyncIn;
   logic [SYNC_W-1:0] syncA_r;
   logic [SYNC_W-1:0] syncB_r;
   logic              swClkDly_r;

   assign asyncIn = {supplyIn, phaseCount, ref_select_high, ref_select_low,
                     switchClock, senseIn, gateIn};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         syncA_r <= '0;
         syncB_r <= '0;
         swClkDly_r <= 1'b0;
      end else begin
         syncA_r <= asyncIn;
         syncB_r <= syncA_r;
         swClkDly_r <= syncB_r[11];
      end
   end

   sps_pkg::sps_supply_t supply;
   sps_pkg::sps_sense_t  sense;
   sps_pkg::sps_gate_t   gate;
   logic [1:0]           phases;
   logic [1:0]           refSel;
   logic                 swClkSync;

   assign supply    = syncB_r[21:16];
   assign phases    = syncB_r[15:14];
   assign refSel    = syncB_r[13:12];
   assign swClkSync = syncB_r[11];
   assign sense     = syncB_r[10:6];
   assign gate      = syncB_r[5:0];

   // (R20) One tick per switching cycle
   wire swTick = swClkSync & ~swClkDly_r;

   // ==========================================================
   // Enable comparator and start condition
   logic enableLevel_r;
   logic enableLevel_nxt;

   // (R3) Rise at 0.66V, fall 100mV lower
   assign enableLevel_nxt = supply.enableAboveRise
                          | (enableLevel_r & supply.enableAboveFall);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) enableLevel_r <= 1'b0;
      else          enableLevel_r <= enableLevel_nxt;
   end

   // (R4) Extra driver supplies for more phases
   wire secondOk = (phases < 2'h2) | supply.secondDriverPor;
   wire thirdOk  = (phases < 2'h3) | supply.thirdDriverPor;

   // (R2) All five conditions together
   wire startOk = supply.logicPor & enableLevel_r
                & supply.firstDriverPor & secondOk & thirdOk;

   // ==========================================================
   // Ramp target select
   logic [10:0] rampTarget;

   // (R21) Four fixed levels
   assign rampTarget = (refSel == 2'h0) ? sps_pkg::RAMP0_CYCLES :
                       (refSel == 2'h1) ? sps_pkg::RAMP1_CYCLES :
                       (refSel == 2'h2) ? sps_pkg::RAMP2_CYCLES :
                                          sps_pkg::RAMP3_CYCLES;

   // ==========================================================
   // Soft-start sequencer
   sps_pkg::sps_seq_t state_r;
   sps_pkg::sps_seq_t state_nxt;
   logic [6:0]        delayCnt_r;
   logic [6:0]        delayCnt_nxt;
   logic [10:0]       rampCnt_r;
   logic [10:0]       rampCnt_nxt;

   // (R7) Exit on 64th tick
   wire delayDone = swTick & (delayCnt_r == sps_pkg::DELAY_CYCLES - 7'h1);
   // (R5) End at target count
   wire rampDone  = rampCnt_r >= rampTarget;

   always_comb begin
      state_nxt    = state_r;
      delayCnt_nxt = delayCnt_r;
      rampCnt_nxt  = rampCnt_r;
      case (state_r)
         sps_pkg::SEQ_SHUTDOWN: begin
            // (R2) Start at once
            if (startOk) state_nxt = sps_pkg::SEQ_DELAY;
         end
         sps_pkg::SEQ_DELAY: begin
            // (R7) Fixed 64-cycle wait
            if (swTick) delayCnt_nxt = delayCnt_r + 7'h1;
            if (delayDone) state_nxt = sps_pkg::SEQ_RAMP;
         end
         sps_pkg::SEQ_RAMP: begin
            // (R5) Linear ramp one step per cycle
            if (rampDone) state_nxt = sps_pkg::SEQ_RUN;
            else if (swTick) rampCnt_nxt = rampCnt_r + 11'h1;
         end
         sps_pkg::SEQ_RUN: begin
            rampCnt_nxt = rampTarget;
         end
         default: state_nxt = sps_pkg::SEQ_SHUTDOWN;
      endcase
      // (R20) Any loss of conditions clears all
      if (!startOk) begin
         state_nxt    = sps_pkg::SEQ_SHUTDOWN;
         delayCnt_nxt = sps_pkg::DELAY_RESET;
         rampCnt_nxt  = sps_pkg::RAMP_RESET;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r    <= sps_pkg::SEQ_SHUTDOWN;
         delayCnt_r <= sps_pkg::DELAY_RESET;
         rampCnt_r  <= sps_pkg::RAMP_RESET;
      end else begin
         state_r    <= state_nxt;
         delayCnt_r <= delayCnt_nxt;
         rampCnt_r  <= rampCnt_nxt;
      end
   end

   // ==========================================================
   // Reference and sense offset codes
   logic [10:0] refCode_nxt;
   logic [10:0] offset_nxt;
   // Offset applies in delay and ramp only
   wire         inSoftStart = (state_nxt == sps_pkg::SEQ_DELAY)
                            | (state_nxt == sps_pkg::SEQ_RAMP);

   // (R5) Reference follows ramp count
   assign refCode_nxt = rampCnt_nxt;

   // (R8) Full offset at start, zero after 640
   assign offset_nxt = (inSoftStart & (rampCnt_nxt < sps_pkg::OFFSET_CYCLES))
                     ? sps_pkg::OFFSET_CYCLES - rampCnt_nxt : 11'h000;

   // ==========================================================
   // Drive release during soft-start
   logic drivesOn_r;
   logic drivesOn_nxt;

   // Sticky once released, ramp noise cannot re-float
   // (R6) (R9) Float until ramp passes feedback
   // (R10) Precharged output waits for ramp end
   assign drivesOn_nxt =
      (state_nxt == sps_pkg::SEQ_RUN) |
      ((state_nxt == sps_pkg::SEQ_RAMP) &
       (drivesOn_r | ~sense.feedbackAboveRamp));

   // ==========================================================
   // Undervoltage latch and power good
   logic underVolt_r;
   logic underVolt_nxt;
   logic goodLevel;

   // (R14) Trip at 82%, no other action
   // (R15) Release above 85%, set wins
   assign underVolt_nxt = (state_nxt != sps_pkg::SEQ_SHUTDOWN) &
                          (sense.belowUnderTrip |
                           (underVolt_r & ~sense.aboveUnderRelease));

   // (R11) (R12) (R13) Good only after soft-start, no faults
   assign goodLevel = (state_nxt == sps_pkg::SEQ_RUN) & ~underVolt_nxt
                    & ~sense.overVoltage & ~sense.overCurrent;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         drivesOn_r      <= 1'b0;
         underVolt_r     <= 1'b0;
         refCode         <= sps_pkg::RAMP_RESET;
         senseOffsetCode <= sps_pkg::RAMP_RESET;
         powerGoodOe     <= 1'b1;
         softStartDone   <= 1'b0;
         seqState        <= sps_pkg::SEQ_SHUTDOWN;
      end else begin
         drivesOn_r      <= drivesOn_nxt;
         underVolt_r     <= underVolt_nxt;
         refCode         <= refCode_nxt;
         senseOffsetCode <= offset_nxt;
         // (R11) Pull low while not good
         powerGoodOe     <= ~goodLevel;
         softStartDone   <= state_nxt == sps_pkg::SEQ_RUN;
         seqState        <= state_nxt;
      end
   end

   // (R11) Open drain only ever pulls low
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) power_good_output <= 1'b0;
      else          power_good_output <= 1'b0;
   end

   // ==========================================================
   // Adaptive deadtime gate sequencer
   sps_pkg::sps_gate_st_t gState_r;
   sps_pkg::sps_gate_st_t gState_nxt;
   logic [3:0]            blankCnt_r;
   logic [3:0]            blankCnt_nxt;
   logic [3:0]            halfCnt_r;
   logic [3:0]            halfCnt_nxt;

   // (R18) Switch-node trips masked while blanking
   wire blanked = blankCnt_r < sps_pkg::BLANK_CYCLES;
   // (R16) Forward or reverse current trip
   wire switchTrip = ~blanked & (gate.switchFwdTrip | gate.switchRevTrip);
   // (R17) Zero-load timeout after lower gate low
   wire zeroLoadGo = halfCnt_r >= sps_pkg::ZERO_LOAD_DT_CYCLES;
   // (R19) Upper near switch node or switch low
   wire lowerGo = gate.upperNearSwitch | gate.switchBelowRev;

   always_comb begin
      gState_nxt   = gState_r;
      blankCnt_nxt = sps_pkg::DT_RESET;
      halfCnt_nxt  = sps_pkg::DT_RESET;
      case (gState_r)
         sps_pkg::GATE_OFF: begin
            if (drivesOn_r) begin
               if (gate.pwmIn) gState_nxt = sps_pkg::GATE_UPPER;
               else            gState_nxt = sps_pkg::GATE_LOWER;
            end
         end
         sps_pkg::GATE_LOWER: begin
            if (gate.pwmIn) gState_nxt = sps_pkg::GATE_WAIT_UP;
         end
         sps_pkg::GATE_WAIT_UP: begin
            blankCnt_nxt = blanked ? blankCnt_r + 4'h1 : blankCnt_r;
            if (gate.lowerBelowHalf && !zeroLoadGo)
               halfCnt_nxt = halfCnt_r + 4'h1;
            else if (gate.lowerBelowHalf)
               halfCnt_nxt = halfCnt_r;
            if (!gate.pwmIn)
               gState_nxt = sps_pkg::GATE_LOWER;
            else if (switchTrip || zeroLoadGo)
               gState_nxt = sps_pkg::GATE_UPPER;
         end
         sps_pkg::GATE_UPPER: begin
            if (!gate.pwmIn) gState_nxt = sps_pkg::GATE_WAIT_LOW;
         end
         sps_pkg::GATE_WAIT_LOW: begin
            if (gate.pwmIn)   gState_nxt = sps_pkg::GATE_UPPER;
            else if (lowerGo) gState_nxt = sps_pkg::GATE_LOWER;
         end
         default: gState_nxt = sps_pkg::GATE_OFF;
      endcase
      // (R1) (R9) Both gates off while drives held
      // Same-cycle drop keeps gates inside enable
      if (!drivesOn_nxt) begin
         gState_nxt = sps_pkg::GATE_OFF;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gState_r   <= sps_pkg::GATE_OFF;
         blankCnt_r <= sps_pkg::DT_RESET;
         halfCnt_r  <= sps_pkg::DT_RESET;
      end else begin
         gState_r   <= gState_nxt;
         blankCnt_r <= blankCnt_nxt;
         halfCnt_r  <= halfCnt_nxt;
      end
   end

   // ==========================================================
   // Registered gate and pulse-output enables
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pwmOutEnable     <= 1'b0;
         upper_gate_drive <= 1'b0;
         lower_gate_drive <= 1'b0;
      end else begin
         // (R1) (R6) High impedance until released
         pwmOutEnable     <= drivesOn_nxt;
         upper_gate_drive <= gState_nxt == sps_pkg::GATE_UPPER;
         lower_gate_drive <= gState_nxt == sps_pkg::GATE_LOWER;
      end
   end

endmodule

// *** hdl/sps_pkg.sv ***
// ==========================================================
// Shared constants and carriers
package sps_pkg;

   // ==========================================================
   // Clock and switching-cycle timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam logic [6:0]  DELAY_CYCLES  = 7'h40;
   localparam int unsigned RAMP_PER_VOLT = 1280;
   localparam int unsigned OFFSET_MV     = 100;
   localparam logic [10:0] OFFSET_CYCLES = 11'h280;

   // Reference levels in millivolts, ramp length in switching cycles
   localparam int unsigned REF_SELECT_LOW_MV = 600;
   localparam int unsigned REF_SELECT_HIGH_MV = 900;
   localparam int unsigned REF2_MV = 1200;
   localparam int unsigned REF3_MV = 1500;
   localparam logic [10:0] RAMP0_CYCLES = 11'(REF_SELECT_LOW_MV * RAMP_PER_VOLT / 1000);
   localparam logic [10:0] RAMP1_CYCLES = 11'(REF_SELECT_HIGH_MV * RAMP_PER_VOLT / 1000);
   localparam logic [10:0] RAMP2_CYCLES = 11'(REF2_MV * RAMP_PER_VOLT / 1000);
   localparam logic [10:0] RAMP3_CYCLES = 11'(REF3_MV * RAMP_PER_VOLT / 1000);

   // ==========================================================
   // Gate deadtime timing
   localparam int unsigned ZERO_LOAD_DT_NS = 35;
   localparam logic [3:0]  ZERO_LOAD_DT_CYCLES =
      4'((ZERO_LOAD_DT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  BLANK_CYCLES = 4'h2;

   // ==========================================================
   // Reset values
   localparam logic [10:0] RAMP_RESET   = 11'h000;
   localparam logic [6:0]  DELAY_RESET  = 7'h00;
   localparam logic [3:0]  DT_RESET     = 4'h0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic logicPor;
      logic firstDriverPor;
      logic secondDriverPor;
      logic thirdDriverPor;
      logic enableAboveRise;
      logic enableAboveFall;
   } sps_supply_t;

   typedef struct packed {
      logic feedbackAboveRamp;
      logic belowUnderTrip;
      logic aboveUnderRelease;
      logic overVoltage;
      logic overCurrent;
   } sps_sense_t;

   typedef struct packed {
      logic pwmIn;
      logic switchFwdTrip;
      logic switchRevTrip;
      logic lowerBelowHalf;
      logic upperNearSwitch;
      logic switchBelowRev;
   } sps_gate_t;

   // ==========================================================
   // State machines
   typedef enum logic [1:0] {
      SEQ_SHUTDOWN = 2'b00,
      SEQ_DELAY    = 2'b01,
      SEQ_RAMP     = 2'b10,
      SEQ_RUN      = 2'b11
   } sps_seq_t;

   typedef enum logic [2:0] {
      GATE_OFF      = 3'b000,
      GATE_LOWER    = 3'b001,
      GATE_WAIT_UP  = 3'b010,
      GATE_UPPER    = 3'b011,
      GATE_WAIT_LOW = 3'b100
   } sps_gate_st_t;

endpackage

// *** dv/sps_checker.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port-level checks
module sps_checker (
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 reset_n,
   // Inputs
   input wire sps_pkg::sps_supply_t supplyIn,
   input wire logic [1:0]           phaseCount,
   input wire logic                 ref_select_low,
   input wire logic                 ref_select_high,
   input wire logic                 switchClock,
   input wire sps_pkg::sps_sense_t  senseIn,
   input wire sps_pkg::sps_gate_t   gateIn,
   // Outputs
   input wire logic                 pwmOutEnable,
   input wire logic                 upper_gate_drive,
   input wire logic                 lower_gate_drive,
   input wire logic [10:0]          refCode,
   input wire logic [10:0]          senseOffsetCode,
   input wire logic                 power_good_output,
   input wire logic                 powerGoodOe,
   input wire logic                 softStartDone,
   input wire sps_pkg::sps_seq_t    seqState
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   AST_SHUT_FLOAT: assert property (
      seqState == sps_pkg::SEQ_SHUTDOWN |-> !pwmOutEnable)
      else $error("pulse outputs driven in shutdown");
   AST_GATES_HELD: assert property (
      !pwmOutEnable |-> !upper_gate_drive && !lower_gate_drive)
      else $error("gate on while drives floating");
   AST_DELAY_FLOAT: assert property (
      seqState == sps_pkg::SEQ_DELAY |-> !pwmOutEnable)
      else $error("pulse outputs driven before ramp");
   AST_NO_OVERLAP: assert property (
      !(upper_gate_drive && lower_gate_drive))
      else $error("both gates on");
   AST_UPPER_WAIT: assert property (
      $rose(upper_gate_drive) |-> !$past(lower_gate_drive, 2))
      else $error("upper released inside blanking");
   AST_OFFSET_LOAD: assert property (
      seqState == sps_pkg::SEQ_DELAY &&
      $past(seqState) == sps_pkg::SEQ_SHUTDOWN |-> senseOffsetCode == 11'h280)
      else $error("sense offset not loaded at start");
   AST_RAMP_STEP: assert property (
      $past(seqState) == sps_pkg::SEQ_RAMP && seqState == sps_pkg::SEQ_RAMP
      |-> refCode == $past(refCode) || refCode == $past(refCode) + 11'h1)
      else $error("ramp step not linear");
   AST_PG_LOW: assert property (
      !power_good_output)
      else $error("power good data not low");
   AST_PG_SHUT: assert property (
      seqState == sps_pkg::SEQ_SHUTDOWN &&
      $past(seqState) == sps_pkg::SEQ_SHUTDOWN |-> powerGoodOe)
      else $error("power good released in shutdown");
   AST_UV_TRIP: assert property (
      senseIn.belowUnderTrip [*5] |-> powerGoodOe)
      else $error("undervoltage left power good high");
   AST_DISABLE: assert property (
      !supplyIn.enableAboveFall [*7] |->
      seqState == sps_pkg::SEQ_SHUTDOWN && powerGoodOe)
      else $error("disable did not shut down");
endmodule

// *** dv/sps_stage_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Power stage and comparator model
module sps_stage_model (
   // Clock and reset
   input wire logic          clock,
   input wire logic          reset_n,
   // Drives and ramp
   input wire logic          upper_gate_drive,
   input wire logic          lower_gate_drive,
   input wire logic [10:0]   refCode,
   // Scenario knobs
   input wire logic [10:0]   preBias,
   input wire logic          zeroLoad,
   input wire logic          pwmIn,
   // Comparators
   output logic              switchClock,
   output logic              feedbackAboveRamp,
   output sps_pkg::sps_gate_t gateIn
);
   logic [1:0] divCnt;
   logic [1:0] lowHist;
   logic [1:0] upHist;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         divCnt <= 2'h0;
         lowHist <= 2'h0;
         upHist <= 2'h0;
      end else begin
         divCnt <= divCnt + 2'h1;
         lowHist <= {lowHist[0], lower_gate_drive};
         upHist <= {upHist[0], upper_gate_drive};
      end
   end
   assign switchClock = divCnt[1];
   // Output held at the precharge level
   assign feedbackAboveRamp = preBias > refCode;
   // Node trips only with load current
   assign gateIn = {pwmIn, !zeroLoad && lowHist == 2'h0, 1'b0,
                    !lowHist[0], !upHist[0], upHist == 2'h0};
endmodule

// *** dv/softstart_powergood_sequencer_tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench top
module softstart_powergood_sequencer_tb;
   logic clock, reset_n, ref_select_low, ref_select_high, switchClock;
   logic pwmOutEnable, upper_gate_drive, lower_gate_drive, softStartDone;
   logic power_good_output, powerGoodOe, fbAbove, zeroLoad, pwmIn, swPrev;
   logic uv, uvRel, ov, oc, rampEn;
   logic [1:0] phaseCount;
   logic [10:0] refCode, senseOffsetCode, preBias, tgt;
   sps_pkg::sps_supply_t supplyIn;
   sps_pkg::sps_sense_t senseIn;
   sps_pkg::sps_gate_t gateIn;
   sps_pkg::sps_seq_t seqState;
   int error_cnt, n_checks, ticks, n;
   assign senseIn = {fbAbove, uv, uvRel, ov, oc};
   sps_sequencer dut (.clock, .reset_n, .supplyIn, .phaseCount,
      .ref_select_low, .ref_select_high, .switchClock, .senseIn, .gateIn,
      .pwmOutEnable, .upper_gate_drive, .lower_gate_drive, .refCode,
      .senseOffsetCode, .power_good_output, .powerGoodOe, .softStartDone,
      .seqState);
   sps_stage_model stage (.clock, .reset_n, .upper_gate_drive,
      .lower_gate_drive, .refCode, .preBias, .zeroLoad, .pwmIn,
      .switchClock, .feedbackAboveRamp(fbAbove), .gateIn);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      swPrev <= switchClock;
      if (seqState === sps_pkg::SEQ_DELAY && switchClock && !swPrev) ticks++;
      if (seqState === sps_pkg::SEQ_RAMP && pwmOutEnable) rampEn = 1'b1;
   end
   task automatic check(string name, logic [10:0] seen, logic [10:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded wait for a state or a gate
   task automatic wait_for(int what);
      n = 0;
      while ((what < 4 ? seqState !== 2'(what) :
              what == 4 ? upper_gate_drive !== 1'b1 :
              lower_gate_drive !== 1'b1)) begin
         @(negedge clock);
         n++;
         if (n > 20000) begin
            check("wait", 11'(n), 11'h0);
            stop_test();
         end
      end
   endtask
   task automatic hold(int c);
      repeat (c) @(negedge clock);
   endtask
   initial begin
      reset_n = 1'b0;
      supplyIn = '0;
      {phaseCount, ref_select_low, ref_select_high} = 4'h4;
      {uv, uvRel, ov, oc, zeroLoad, pwmIn, swPrev} = 7'h0;
      {preBias, ticks, rampEn, error_cnt, n_checks} = '0;
      n = $urandom(86401);
      hold(8);
      reset_n = 1'b1;
      check("reset pgOe", 11'(powerGoodOe), 11'h1);
      for (int i = 0; i < 4; i++) begin
         {ref_select_high, ref_select_low} = 2'(i);
         tgt = 11'((600 + 300 * i) * 1280 / 1000);
         phaseCount = 2'($urandom_range(3, 1));
         preBias = i == 2 ? 11'h7ff : 11'($urandom_range(tgt - 20, 0));
         {ticks, rampEn, uvRel, zeroLoad} = {32'h0, 1'b0, 1'b0, i[0]};
         supplyIn = 6'h3b;
         hold(20);
         check("start", seqState, phaseCount < 3 ? 2'h1 : 2'h0);
         supplyIn = 6'h3f;
         wait_for(3);
         check("delay ticks", 11'(ticks >= 63 && ticks <= 65), 11'h1);
         check("ramp end", refCode, tgt);
         check("offset", senseOffsetCode, 11'h0);
         check("ramp drive", 11'(rampEn), 11'(preBias < tgt));
         hold(4);
         check("drive", 11'({pwmOutEnable, softStartDone}), 11'h3);
         check("pg run", 11'(powerGoodOe), 11'h0);
         uv = 1'b1;
         hold(6);
         check("pg uv", 11'(powerGoodOe), 11'h1);
         check("uv no action", seqState, 2'h3);
         uv = 1'b0;
         hold(6);
         check("pg uv hold", 11'(powerGoodOe), 11'h1);
         uvRel = 1'b1;
         hold(6);
         check("pg uv clear", 11'(powerGoodOe), 11'h0);
         {ov, oc} = i[0] ? 2'h2 : 2'h1;
         hold(6);
         check("pg fault", 11'(powerGoodOe), 11'h1);
         {ov, oc} = 2'h0;
         hold(6);
         check("pg fault clear", 11'(powerGoodOe), 11'h0);
         repeat (3) begin
            pwmIn = 1'b1;
            wait_for(4);
            check("upper dead", 11'(n >= (zeroLoad ? 5 : 2)), 11'h1);
            hold($urandom_range(9, 1));
            pwmIn = 1'b0;
            wait_for(5);
            check("lower on", 11'(upper_gate_drive), 11'h0);
         end
         supplyIn = 6'h3d;
         hold(10);
         check("hysteresis", seqState, 2'h3);
         supplyIn = 6'h3c;
         hold(10);
         check("off", 11'({seqState, pwmOutEnable, powerGoodOe}), 11'h1);
         check("cleared", refCode, 11'h0);
         $display("test %0d done", i);
      end
      stop_test();
   end
endmodule
bind sps_sequencer sps_checker chk (.clock, .reset_n, .supplyIn, .phaseCount,
   .ref_select_low, .ref_select_high, .switchClock, .senseIn, .gateIn,
   .pwmOutEnable, .upper_gate_drive, .lower_gate_drive, .refCode,
   .senseOffsetCode, .power_good_output, .powerGoodOe, .softStartDone,
   .seqState);
